// [hw/sef_pkg.sv]
// Purpose: Constants for the SPI interface error flag bank.
// Assumes: Byte-wide registers on the SPI register port.
// Notes:   Bit positions follow the interface status layout.
package sef_pkg;
   localparam logic [7:0] SEF_STATUS_ADDR   = 8'h11;
   localparam logic [7:0] SEF_CONFIG_ADDR   = 8'h14;
   localparam logic [7:0] SEF_STATUS_RESET  = 8'h00;
   localparam logic [7:0] SEF_CONFIG_RESET  = 8'h04;
   // Reserved config bits 7 and 5 hold zero.
   localparam logic [7:0] SEF_CONFIG_WMASK  = 8'h5F;
   localparam int         SEF_BIT_NOT_READY = 7;
   localparam int         SEF_BIT_CLK_COUNT = 5;
   localparam int         SEF_BIT_CRC       = 3;
   localparam int         SEF_BIT_RO_WRITE  = 2;
   localparam int         SEF_BIT_PARTIAL   = 1;
   localparam int         SEF_BIT_BAD_ADDR  = 0;
   localparam int         SEF_NUM_FLAGS     = 6;
   localparam int         SEF_READY_NS      = 100;
   localparam int         SEF_CLK_NS        = 4;
   localparam int         SEF_READY_CYCLES  = (SEF_READY_NS + SEF_CLK_NS - 1) / SEF_CLK_NS;
endpackage

// [hw/sef_sticky_flag.sv]
// Purpose: One write-one-to-clear sticky flag.
// Assumes: Set and clear are one-cycle pulses.
// Notes:   Set wins over a clear in the same cycle.
`timescale 1ns/100ps
module sef_sticky_flag (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Events
   input  wire logic set,
   input  wire logic clr,
   // State
   output logic      flag
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule

// [hw/sef_error_flags.sv]
// Purpose: Sticky SPI interface error flags and the misc config register.
// Assumes: Detector pulses come one cycle wide from the SPI frame decoder.
// Notes:   Register port is the decoder's internal byte access path.
`timescale 1ns/100ps
module sef_error_flags
   import sef_pkg::*;
#(
   parameter int READY_CYCLES = SEF_READY_CYCLES,
   parameter bit STRICT_MODE  = 1'b1
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Detector pulses from the frame decoder
   input  wire logic       frame_start,
   input  wire logic       sclk_edge_count_fault,
   input  wire logic       crc_fault,
   input  wire logic       ro_target_write_fault,
   input  wire logic       partial_access_fault,
   input  wire logic       bad_address_fault,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Block state
   output logic      [7:0] status,
   output logic      [7:0] misc_config,
   output logic            if_ready,
   output logic            commit_veto
);
   localparam int CW = $clog2(READY_CYCLES + 1);

   // The timer needs at least one cycle, and the flag map is fixed at six cells.
   generate
      if (READY_CYCLES < 1) begin : g_bad_ready
         $error("READY_CYCLES must be at least one");
      end
      if (READY_CYCLES > 65535) begin : g_big_ready
         $error("READY_CYCLES is beyond the timer range");
      end
      if (SEF_NUM_FLAGS != 6) begin : g_bad_flags
         $error("The flag map expects six cells");
      end
   endgenerate

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   // Maps a flag cell index to its bit position in the status byte.
   function automatic int flag_pos(input int idx);
      case (idx)
         0:       flag_pos = SEF_BIT_BAD_ADDR;
         1:       flag_pos = SEF_BIT_PARTIAL;
         2:       flag_pos = SEF_BIT_RO_WRITE;
         3:       flag_pos = SEF_BIT_CRC;
         4:       flag_pos = SEF_BIT_CLK_COUNT;
         5:       flag_pos = SEF_BIT_NOT_READY;
         default: flag_pos = SEF_BIT_BAD_ADDR;
      endcase
   endfunction

   // Unmapped reads return zero; the decoder flags the address itself.
   function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                            input logic [7:0] st,
                                            input logic [7:0] cfg);
      if (hit(addr, SEF_STATUS_ADDR)) begin
         read_byte = st;
      end else if (hit(addr, SEF_CONFIG_ADDR)) begin
         read_byte = cfg;
      end else begin
         read_byte = '0;
      end
   endfunction

   logic [CW-1:0]            ready_cnt;
   logic [SEF_NUM_FLAGS-1:0] set_vec;
   logic [SEF_NUM_FLAGS-1:0] clr_vec;
   logic [SEF_NUM_FLAGS-1:0] flag_vec;
   logic                     status_wr;
   logic                     config_wr;
   logic [7:0]               next_status;

   // The ready timer starts at reset release so no strap is sampled.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ready_cnt <= '0;
      end else if (!if_ready) begin
         ready_cnt <= ready_cnt + CW'(1);
      end
   end

   // Ready is kept as a level so the early frame check needs no extra decode.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         if_ready <= 1'b0;
      end else if (!if_ready) begin
         if_ready <= (ready_cnt == CW'(READY_CYCLES - 1));
      end
   end

   assign status_wr = reg_wr && hit(reg_addr, SEF_STATUS_ADDR);
   assign config_wr = reg_wr && hit(reg_addr, SEF_CONFIG_ADDR);

   assign set_vec[5] = frame_start && !if_ready;
   assign set_vec[4] = sclk_edge_count_fault;
   assign set_vec[3] = crc_fault;
   assign set_vec[2] = ro_target_write_fault;
   assign set_vec[1] = partial_access_fault;
   assign set_vec[0] = bad_address_fault;

   genvar gi;
   generate
      for (gi = 0; gi < SEF_NUM_FLAGS; gi++) begin : g_flag
         assign clr_vec[gi] = status_wr && reg_wdata[flag_pos(gi)];
         sef_sticky_flag u_flag (
            .clk   (clk),
            .rst_b (rst_b),
            .set   (set_vec[gi]),
            .clr   (clr_vec[gi]),
            .flag  (flag_vec[gi])
         );
      end
   endgenerate

   always_comb begin
      next_status                    = SEF_STATUS_RESET;
      next_status[SEF_BIT_NOT_READY] = flag_vec[5];
      next_status[SEF_BIT_CLK_COUNT] = flag_vec[4];
      next_status[SEF_BIT_CRC]       = flag_vec[3];
      next_status[SEF_BIT_RO_WRITE]  = flag_vec[2];
      next_status[SEF_BIT_PARTIAL]   = flag_vec[1];
      next_status[SEF_BIT_BAD_ADDR]  = flag_vec[0];
   end

   // Mirrored into a flop so the output is registered; lags the cells by one edge.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= SEF_STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         misc_config <= SEF_CONFIG_RESET;
      end else if (config_wr) begin
         misc_config <= reg_wdata & SEF_CONFIG_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         commit_veto <= 1'b0;
      end else begin
         commit_veto <= STRICT_MODE && partial_access_fault;
      end
   end

   // Status reads come from the cells, one edge ahead of the status output.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= read_byte(reg_addr, next_status, misc_config);
      end
   end
endmodule

// [verif/sef_error_flags_assertions.sv]
// Purpose: Timing checks on the error flag bank ports.
// Assumes: Flags show on status two edges after a detector pulse.
// Notes:   Bound to every instance of the flag bank.
`timescale 1ns/100ps
module sef_error_flags_assertions
   import sef_pkg::*;
(
   input wire logic       clk, rst_b, frame_start, sclk_edge_count_fault, crc_fault,
   input wire logic       ro_target_write_fault, partial_access_fault, bad_address_fault,
   input wire logic       reg_wr, reg_rd, if_ready, commit_veto,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, status, misc_config
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ccount_set_a: assert property (sclk_edge_count_fault |-> ##2 status[5])
      else $error("Clock count flag missed.");
   crc_set_a: assert property (crc_fault |-> ##2 status[3])
      else $error("CRC flag missed.");
   ro_write_set_a: assert property (ro_target_write_fault |-> ##2 status[2])
      else $error("Read-only write flag missed.");
   partial_set_a: assert property (partial_access_fault |-> ##2 status[1])
      else $error("Partial access flag missed.");
   bad_addr_set_a: assert property (bad_address_fault |-> ##2 status[0])
      else $error("Bad address flag missed.");
   not_ready_set_a: assert property (frame_start && !if_ready |-> ##2 status[7])
      else $error("Not ready flag missed.");
   veto_cause_a: assert property (commit_veto |-> $past(partial_access_fault))
      else $error("Veto without partial access.");
   flag_sticky_a: assert property (|($past(status) & ~status)
      |-> $past(reg_wr && reg_addr == SEF_STATUS_ADDR, 2)) else $error("Flag lost.");
   resv_zero_a: assert property (!status[4] && !status[6])
      else $error("Reserved status bit set.");
endmodule
bind sef_error_flags sef_error_flags_assertions sef_chk_i (.*);

// [verif/sef_host_model.sv]
// Purpose: Frame decoder and host side driving the flag bank.
// Assumes: Requests change just after a rising edge.
// Notes:   Address is inverted on release so stale values never look valid.
`timescale 1ns/100ps
module sef_host_model (
   // Clock
   input  wire logic       clk,
   // Decoder side
   output logic      [5:0] det,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial begin
      det = 6'h00;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
   end
   task automatic pulse(input logic [5:0] e);
      @(posedge clk) det <= e;
      @(posedge clk) det <= 6'h00;
   endtask
   task automatic access(input logic w, input logic [7:0] a, d);
      @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
   endtask
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the error flag bank.
// Assumes: Ready timer shortened to 8 cycles.
// Notes:   Reset and config expected values come from the package constants; status expectations are literals.
`timescale 1ns/100ps
module testbench
   import sef_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [5:0] det;
   logic       reg_wr, reg_rd, if_ready, commit_veto;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, status, misc_config;
   int         miscompares = 0, total_checks = 0, cycles = 0;
   always #2 clk = ~clk;
   sef_host_model sef_host_model_i (.clk(clk), .det(det), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   sef_error_flags #(.READY_CYCLES(8)) sef_error_flags_i (.clk(clk), .rst_b(rst_b),
      .frame_start(det[5]), .sclk_edge_count_fault(det[4]), .crc_fault(det[3]),
      .ro_target_write_fault(det[2]), .partial_access_fault(det[1]),
      .bad_address_fault(det[0]), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status(status),
      .misc_config(misc_config), .if_ready(if_ready), .commit_veto(commit_veto));
   task automatic check(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      sef_host_model_i.access(1'b0, a, 8'h00);
      settle();
      check("read data", reg_rdata, exp);
   endtask
   task automatic test_done();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic scn_not_ready();
      sef_host_model_i.pulse(6'h20);
      settle();
      check("early frame", status, 8'h80);
      repeat (8) @(posedge clk);
      sef_host_model_i.access(1'b1, SEF_STATUS_ADDR, 8'h80);
      sef_host_model_i.pulse(6'h20);
      settle();
      check("ready frame", status, 8'h00);
   endtask
   task automatic scn_flags();
      logic [7:0] m;
      for (int j = 0; j < 5; j++) begin
         m = (j == 4) ? 8'h20 : 8'h01 << j;
         sef_host_model_i.pulse(6'h01 << j);
         #1;
         check("commit veto", {7'h00, commit_veto}, (j == 1) ? 8'h01 : 8'h00);
         settle();
         check("flag set", status, m);
         rd(SEF_STATUS_ADDR, m);
         sef_host_model_i.access(1'b1, SEF_STATUS_ADDR, ~m);
         settle();
         check("zero write", status, m);
         sef_host_model_i.access(1'b1, SEF_STATUS_ADDR, m);
         settle();
         check("one write", status, 8'h00);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      check("reset status", status, SEF_STATUS_RESET);
      scn_not_ready();
      rd(SEF_CONFIG_ADDR, SEF_CONFIG_RESET);
      sef_host_model_i.access(1'b1, SEF_CONFIG_ADDR, 8'hFF);
      rd(SEF_CONFIG_ADDR, SEF_CONFIG_WMASK);
      scn_flags();
      test_done();
   end
endmodule
